// ===== rtl/etei_pkg.sv
package etei_pkg;
  // source numbering: fast pins, then regular pins, then the two capture inputs
  localparam int NSRC = 10;
  localparam int NFAST = 3;
  localparam int NREG = 5;
  localparam int SRC_AUXA = 8;
  localparam int SRC_AUXB = 9;

  // clock half periods per event; one clk_sys cycle is one clock half period
  localparam logic [4:0] HP_PER_STATE = 5'h02;
  localparam logic [4:0] HP_FAST_SAMPLE = 5'h02;
  localparam logic [4:0] HP_ARB = 5'h08;
  localparam logic [4:0] HP_REG_SAMPLE = 5'h10;

  // response figures in states; EXT_WORST_WORDS and EXT_FETCH_WORDS in bus words
  localparam logic [3:0] MIN_LAST = 4'h3;
  localparam logic [3:0] MIN_FIRST = 4'h4;
  localparam logic [3:0] HOLD_ADD = 4'h1;
  localparam logic [3:0] CODE_ADD = 4'h2;
  localparam logic [3:0] FLAGS_ADD = 4'h2;
  localparam logic [3:0] REPEAT_ADD = 4'h1;
  localparam logic [3:0] MAX_INT = 4'h9;
  localparam logic [3:0] FINISH_STATES = 4'h2;
  localparam logic [3:0] EXT_WORST_WORDS = 4'h7;
  localparam logic [3:0] EXT_FETCH_WORDS = 4'h1;
  localparam logic [3:0] EXT_FETCH_TAIL = 4'h2;

  // register byte addresses
  localparam logic [15:0] ADDR_FAST_CFG = 16'hdf00;
  localparam logic [15:0] ADDR_AUXA_CTL = 16'hdf04;
  localparam logic [15:0] ADDR_AUXB_CTL = 16'hdf08;
  localparam logic [15:0] ADDR_FLAGS = 16'hdf0c;
  localparam logic [15:0] ADDR_ENABLE = 16'hdf10;
  localparam logic [15:0] ADDR_XSEL = 16'hdf14;
  localparam logic [15:0] ADDR_AUXA_VAL = 16'hdf18;
  localparam logic [15:0] ADDR_AUXB_VAL = 16'hdf1c;
  localparam logic [15:0] ADDR_STATUS = 16'hdf20;
  localparam logic [15:0] ADDR_REG_CFG = 16'hdf38;

  // reset values
  localparam logic [9:0] RST_REG_CFG = 10'h000;
  localparam logic [5:0] RST_FAST_CFG = 6'h00;
  localparam logic [5:0] RST_AUX_CTL = 6'h00;
  localparam logic [9:0] RST_SRC = 10'h000;

  // capture timer control fields
  localparam int AUX_MODE_LSB = 0;
  localparam int AUX_EDGE_LSB = 3;
  localparam logic [2:0] AUX_CAPTURE = 3'h5;

  // two-bit edge selections
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ARB = 5'h02,
    ST_WAIT = 5'h04,
    ST_INJECT = 5'h08,
    ST_FINISH = 5'h10
  } etei_state_type;
endpackage : etei_pkg

// ===== rtl/etei_top.sv
// Overview of operation
// RQ1 - transfer starts two instruction cycles after flag
// RQ2 - winner injected, next instruction held, flag cleared
// RQ3 - injected transfer finishes, held instruction resumes
// RQ4 - later instructions wait for transfer end
// RQ5 - control register read repeats round, one later
// RQ6 - minimum three or four states by flag phase
// RQ7 - each hold condition adds one state
// RQ8 - code operand or call adds two states
// RQ9 - status word read after flag change adds two
// RQ10 - internal response never above nine states
// RQ11 - all external pending takes seven bus words
// RQ12 - external fetch only: one word plus two
// RQ13 - after acknowledge, two states plus slow accesses
// RQ14 - fast pins: rising, falling or any edge
// RQ15 - regular pins: rising, falling or high level
// RQ16 - regular pins sampled every sixteen half periods
// RQ17 - capture mode turns timer pin into interrupt
// RQ18 - capture edge field picks rising, falling, both
// RQ19 - selected edge copies core timer into register
// RQ20 - enabled flag gives transfer or interrupt request
// RQ21 - fast pins every two, arbitration every eight
// RQ22 - fast edge field: off, rise, fall, any
// RQ23 - edges found by comparing synchronized samples
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps

module etei_edge (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // sampling
  input wire logic sample_en,
  input wire logic pin,
  input wire logic [1:0] sel,
  input wire logic level_on_any,
  // result
  output logic hit
);
  logic prev_q;
  wire rise_w;
  wire fall_w;
  wire any_w;

  // previous sample, taken only at the sampling interval
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
    end else if (sample_en) begin
      prev_q <= pin;
    end
  end

  // compare two successive samples
  assign rise_w = pin & ~prev_q; // RQ23
  assign fall_w = ~pin & prev_q;
  assign any_w = level_on_any ? pin : (rise_w | fall_w);
  assign hit = sample_en & ((sel == etei_pkg::EDGE_RISE) & rise_w |
                            (sel == etei_pkg::EDGE_FALL) & fall_w |
                            (sel == etei_pkg::EDGE_ANY) & any_w); // RQ22
endmodule : etei_edge

module etei_top #(
  parameter int TIMER_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external pins
  input wire logic [2:0] fast_irq_pin,
  input wire logic [4:0] regular_irq_pin,
  input wire logic aux_timer_a_input_pin,
  input wire logic aux_timer_b_input_pin,
  // core timer value
  input wire logic [TIMER_W-1:0] core_timer,
  // pipeline conditions of the current instruction
  input wire logic cpu_last_state,
  input wire logic cpu_hold_early,
  input wire logic cpu_hold_late,
  input wire logic cpu_code_or_call,
  input wire logic cpu_reads_status,
  input wire logic cpu_prev_sets_flags,
  input wire logic cpu_reads_xfer_ctrl,
  input wire logic cpu_ext_fetch,
  input wire logic cpu_ext_read,
  input wire logic cpu_ext_write,
  input wire logic bus_access_done,
  input wire logic xfer_src_slow,
  input wire logic xfer_dst_ext,
  // transfer and interrupt requests
  output logic xfer_start,
  output logic [3:0] xfer_channel,
  output logic hold_next,
  output logic xfer_done,
  output logic irq_req,
  output logic [3:0] irq_vector
);
  localparam int N = etei_pkg::NSRC;

  generate
    if (TIMER_W < 1 || TIMER_W > 32) begin : g_bad_width
      $error("TIMER_W must be 1 to 32");
    end
  endgenerate

  function automatic logic [3:0] etei_first(input logic [N-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : etei_first

  etei_pkg::etei_state_type state_q, state_d;
  logic [3:0] div_q;
  logic [9:0] sync1_q, sync2_q;
  logic [9:0] reg_cfg_q;
  logic [5:0] fast_cfg_q, auxa_ctl_q, auxb_ctl_q;
  logic [N-1:0] flags_q, enable_q, xsel_q;
  logic [TIMER_W-1:0] auxa_q, auxb_q;
  logic [3:0] target_q, cnt_q, ext_left_q, chan_q, vec_q, last_resp_q;
  logic set_last_q, done_q, irq_q;
  logic [31:0] prdata_q;
  logic err_q;

  // slower rates as enables from the half-period divider
  wire state_en = (div_q & 4'(etei_pkg::HP_PER_STATE - 5'h01)) == 4'(etei_pkg::HP_PER_STATE - 5'h01);
  wire fast_en = (div_q & 4'(etei_pkg::HP_FAST_SAMPLE - 5'h01)) == 4'(etei_pkg::HP_FAST_SAMPLE - 5'h01);
  wire arb_en = (div_q & 4'(etei_pkg::HP_ARB - 5'h01)) == 4'(etei_pkg::HP_ARB - 5'h01);
  wire reg_en = div_q == 4'(etei_pkg::HP_REG_SAMPLE - 5'h01);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // two-flop synchronisers on every pin
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
    end else begin
      sync1_q <= {aux_timer_b_input_pin, aux_timer_a_input_pin, regular_irq_pin, fast_irq_pin};
      sync2_q <= sync1_q;
    end
  end

  // edge detectors per source
  wire [N-1:0] hit;
  wire auxa_cap = auxa_ctl_q[etei_pkg::AUX_MODE_LSB +: 3] == etei_pkg::AUX_CAPTURE; // RQ17
  wire auxb_cap = auxb_ctl_q[etei_pkg::AUX_MODE_LSB +: 3] == etei_pkg::AUX_CAPTURE; // RQ17
  wire [1:0] auxa_sel = auxa_cap ? auxa_ctl_q[etei_pkg::AUX_EDGE_LSB +: 2] : etei_pkg::EDGE_OFF; // RQ18
  wire [1:0] auxb_sel = auxb_cap ? auxb_ctl_q[etei_pkg::AUX_EDGE_LSB +: 2] : etei_pkg::EDGE_OFF; // RQ18

  genvar g;
  generate
    for (g = 0; g < etei_pkg::NFAST; g++) begin : g_fast
      etei_edge u_edge (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .sample_en(fast_en), // RQ21
        .pin(sync2_q[g]),
        .sel(fast_cfg_q[2*g +: 2]), // RQ14
        .level_on_any(1'b0),
        .hit(hit[g])
      );
    end
    for (g = 0; g < etei_pkg::NREG; g++) begin : g_reg
      etei_edge u_edge (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .sample_en(reg_en), // RQ16
        .pin(sync2_q[etei_pkg::NFAST + g]),
        .sel(reg_cfg_q[2*g +: 2]),
        .level_on_any(1'b1), // RQ15
        .hit(hit[etei_pkg::NFAST + g])
      );
    end
  endgenerate

  etei_edge u_auxa (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .sample_en(state_en),
    .pin(sync2_q[etei_pkg::SRC_AUXA]),
    .sel(auxa_sel),
    .level_on_any(1'b0),
    .hit(hit[etei_pkg::SRC_AUXA])
  );

  etei_edge u_auxb (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .sample_en(state_en),
    .pin(sync2_q[etei_pkg::SRC_AUXB]),
    .sel(auxb_sel),
    .level_on_any(1'b0),
    .hit(hit[etei_pkg::SRC_AUXB])
  );

  // apb decode; zero wait states, unmapped addresses answer with an error
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  wire a_fast = paddr == etei_pkg::ADDR_FAST_CFG;
  wire a_auxa = paddr == etei_pkg::ADDR_AUXA_CTL;
  wire a_auxb = paddr == etei_pkg::ADDR_AUXB_CTL;
  wire a_flags = paddr == etei_pkg::ADDR_FLAGS;
  wire a_en = paddr == etei_pkg::ADDR_ENABLE;
  wire a_xsel = paddr == etei_pkg::ADDR_XSEL;
  wire a_av = paddr == etei_pkg::ADDR_AUXA_VAL;
  wire a_bv = paddr == etei_pkg::ADDR_AUXB_VAL;
  wire a_stat = paddr == etei_pkg::ADDR_STATUS;
  wire a_reg = paddr == etei_pkg::ADDR_REG_CFG;
  wire a_any = a_fast | a_auxa | a_auxb | a_flags | a_en | a_xsel | a_av | a_bv | a_stat | a_reg;
  wire [31:0] rd_mux = ({32{a_fast}} & {26'h0, fast_cfg_q}) |
                       ({32{a_auxa}} & {26'h0, auxa_ctl_q}) |
                       ({32{a_auxb}} & {26'h0, auxb_ctl_q}) |
                       ({32{a_flags}} & {22'h0, flags_q}) |
                       ({32{a_en}} & {22'h0, enable_q}) |
                       ({32{a_xsel}} & {22'h0, xsel_q}) |
                       ({32{a_av}} & 32'(auxa_q)) |
                       ({32{a_bv}} & 32'(auxb_q)) |
                       ({32{a_stat}} & {23'h0, state_q, last_resp_q}) |
                       ({32{a_reg}} & {22'h0, reg_cfg_q});
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = err_q;

  // read data and error captured in the setup phase, held through access
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      err_q <= ~a_any;
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_cfg_q <= etei_pkg::RST_REG_CFG;
      fast_cfg_q <= etei_pkg::RST_FAST_CFG;
      auxa_ctl_q <= etei_pkg::RST_AUX_CTL;
      auxb_ctl_q <= etei_pkg::RST_AUX_CTL;
      enable_q <= etei_pkg::RST_SRC;
      xsel_q <= etei_pkg::RST_SRC;
    end else if (wr) begin
      if (a_reg) reg_cfg_q <= pwdata[9:0];
      if (a_fast) fast_cfg_q <= pwdata[5:0];
      if (a_auxa) auxa_ctl_q <= pwdata[5:0];
      if (a_auxb) auxb_ctl_q <= pwdata[5:0];
      if (a_en) enable_q <= pwdata[N-1:0];
      if (a_xsel) xsel_q <= pwdata[N-1:0];
    end
  end

  // capture core timer on the selected transition
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      auxa_q <= '0;
      auxb_q <= '0;
    end else begin
      if (hit[etei_pkg::SRC_AUXA]) auxa_q <= core_timer; // RQ19
      if (hit[etei_pkg::SRC_AUXB]) auxb_q <= core_timer; // RQ19
    end
  end

  // request flags: write one to clear, service clears the winner, a set wins
  wire inject = state_q == etei_pkg::ST_INJECT;
  wire [N-1:0] svc_clr = inject ? (N'(1) << chan_q) : '0; // RQ2
  wire [N-1:0] sw_clr = (wr & a_flags) ? pwdata[N-1:0] : '0;
  wire [N-1:0] flags_d = (flags_q & ~(svc_clr | sw_clr)) | hit;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_q <= etei_pkg::RST_SRC;
      set_last_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      if (|hit) set_last_q <= cpu_last_state;
    end
  end

  // routing of enabled flags to transfer or interrupt
  wire [N-1:0] xfer_cand = flags_q & enable_q & xsel_q; // RQ20
  wire [N-1:0] irq_cand = flags_q & enable_q & ~xsel_q; // RQ20

  // response time in states from the pipeline conditions
  wire [3:0] base = set_last_q ? etei_pkg::MIN_LAST : etei_pkg::MIN_FIRST; // RQ6
  wire [4:0] sum = {1'b0, base} +
                   (cpu_hold_early ? {1'b0, etei_pkg::HOLD_ADD} : 5'h00) +
                   (cpu_hold_late ? {1'b0, etei_pkg::HOLD_ADD} : 5'h00) + // RQ7
                   (cpu_code_or_call ? {1'b0, etei_pkg::CODE_ADD} : 5'h00) + // RQ8
                   ((cpu_reads_status & cpu_prev_sets_flags) ? {1'b0, etei_pkg::FLAGS_ADD} : 5'h00); // RQ9
  wire [3:0] int_t = (sum > {1'b0, etei_pkg::MAX_INT}) ? etei_pkg::MAX_INT : sum[3:0]; // RQ10
  wire ext_all = cpu_ext_fetch & cpu_ext_read & cpu_ext_write;
  wire ext_some = cpu_ext_fetch | cpu_ext_read | cpu_ext_write;
  wire [3:0] ext_w = ext_all ? etei_pkg::EXT_WORST_WORDS : (ext_some ? etei_pkg::EXT_FETCH_WORDS : 4'h0);
  wire [3:0] tgt = ext_all ? 4'h0 : (ext_some ? etei_pkg::EXT_FETCH_TAIL : int_t); // RQ11 RQ12
  wire [3:0] fin_w = {3'h0, xfer_src_slow} + {3'h0, xfer_dst_ext};
  wire bus_idle = ext_left_q == 4'h0;
  wire arb_win = (state_q == etei_pkg::ST_ARB) & arb_en & (|xfer_cand);

  // state sequence
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      etei_pkg::ST_IDLE: if (|xfer_cand) state_d = etei_pkg::ST_ARB;
      etei_pkg::ST_ARB: begin
        if (arb_en) state_d = (|xfer_cand) ? etei_pkg::ST_WAIT : etei_pkg::ST_IDLE;
      end
      etei_pkg::ST_WAIT: if (bus_idle && cnt_q >= target_q) state_d = etei_pkg::ST_INJECT; // RQ1
      etei_pkg::ST_INJECT: state_d = etei_pkg::ST_FINISH;
      etei_pkg::ST_FINISH: begin
        if (bus_idle && cnt_q >= etei_pkg::FINISH_STATES) state_d = etei_pkg::ST_IDLE; // RQ3 RQ13
      end
      default: state_d = etei_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= etei_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // wait counters; states are only counted once the bus words are through
  wire start_arb = (state_q == etei_pkg::ST_IDLE) & (|xfer_cand);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      target_q <= 4'h0;
      cnt_q <= 4'h0;
      ext_left_q <= 4'h0;
      chan_q <= 4'h0;
    end else begin
      if (start_arb) begin
        target_q <= tgt;
        ext_left_q <= ext_w;
      end else if (inject) begin
        ext_left_q <= fin_w; // RQ13
      end else if (bus_access_done && !bus_idle) begin
        ext_left_q <= ext_left_q - 4'h1;
      end
      if (arb_win) begin
        chan_q <= etei_first(xfer_cand); // RQ2
        if (cpu_reads_xfer_ctrl) target_q <= target_q + etei_pkg::REPEAT_ADD; // RQ5
      end
      if (start_arb || inject) begin
        cnt_q <= 4'h0;
      end else if (state_en && bus_idle && cnt_q != 4'hf) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // outputs; the held instruction stays stalled until the transfer ends
  assign xfer_start = inject;
  assign hold_next = inject | (state_q == etei_pkg::ST_FINISH); // RQ2 RQ4
  assign xfer_channel = chan_q;
  assign xfer_done = done_q;
  assign irq_req = irq_q;
  assign irq_vector = vec_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      done_q <= 1'b0;
      irq_q <= 1'b0;
      vec_q <= 4'h0;
      last_resp_q <= 4'h0;
    end else begin
      done_q <= (state_q == etei_pkg::ST_FINISH) & (state_d == etei_pkg::ST_IDLE); // RQ3
      irq_q <= |irq_cand;
      vec_q <= etei_first(irq_cand);
      if (inject) last_resp_q <= cnt_q;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  set_wins_clear_a: assert property ((|(hit & svc_clr)) |=> (|(flags_q & $past(svc_clr)))) // RQ20
    else $error("flag set lost to clear");
  inject_clears_a: assert property (xfer_start && !hit[chan_q] |=> !flags_q[$past(chan_q)]) // RQ2
    else $error("served flag not cleared");
  hold_until_done_a: assert property (xfer_start |=> (hold_next && !xfer_done)[*4]) // RQ13
    else $error("held instruction resumed early");
  resp_cap_a: assert property (start_arb && !ext_some |=> target_q >= 4'h3 && target_q <= 4'h9) // RQ10
    else $error("internal response out of range");
  min_resp_a: assert property (start_arb && !ext_some && sum == {1'b0, base} |=>
                               target_q == ($past(set_last_q) ? 4'h3 : 4'h4)) // RQ6
    else $error("minimum response wrong");
  repeat_round_a: assert property (arb_win && cpu_reads_xfer_ctrl |=> target_q == $past(target_q) + 4'h1) // RQ5
    else $error("repeated round not delayed");
  ext_worst_a: assert property (start_arb && ext_all |=> ext_left_q == 4'h7 && target_q == 4'h0) // RQ11
    else $error("worst external count wrong");
  capture_a: assert property (hit[etei_pkg::SRC_AUXA] |=> auxa_q == $past(core_timer)) // RQ19
    else $error("capture value wrong");
  fast_rate_a: assert property ((|hit[2:0]) |-> fast_en) // RQ21
    else $error("fast pin hit off interval");
  reg_rate_a: assert property ((|hit[7:3]) |-> reg_en ##1 !reg_en[*8]) // RQ16
    else $error("regular pin hit off interval");
  wait_to_inject_a: assert property (state_q == etei_pkg::ST_WAIT && bus_idle && cnt_q >= target_q |=>
                                     xfer_start) // RQ1
    else $error("transfer not started");

  transfer_c: cover property (xfer_start ##[1:40] xfer_done);
  repeat_c: cover property (arb_win && cpu_reads_xfer_ctrl);
  ext_c: cover property (start_arb && ext_all ##[1:200] xfer_start);
  irq_c: cover property ($rose(irq_req));
endmodule : etei_top

// ===== tb/etei_pin_model.sv
`timescale 1ns/1ps

module etei_pin_model (
  // clock
  input wire logic clk_sys,
  // wanted levels: fast 0-2, regular 3-7, capture a 8, capture b 9
  input wire logic [9:0] want,
  // pins toward the block
  output logic [2:0] fast_irq_pin,
  output logic [4:0] regular_irq_pin,
  output logic aux_timer_a_input_pin,
  output logic aux_timer_b_input_pin
);
  // lines move just after an edge, with no tie to when the block samples them
  always_ff @(posedge clk_sys) begin
    {aux_timer_b_input_pin, aux_timer_a_input_pin, regular_irq_pin, fast_irq_pin} <= want;
  end
endmodule : etei_pin_model

// ===== tb/test_event_transfer_timing_and_ext_irq.sv
`timescale 1ns/1ps

module test_event_transfer_timing_and_ext_irq;
  logic clk_sys = 1'b0;
  logic sys_rst;
  logic psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0] want;
  logic [2:0] fast_irq_pin;
  logic [4:0] regular_irq_pin;
  logic aux_a_pin, aux_b_pin;
  logic [15:0] core_timer;
  logic [9:0] cpu;
  logic bus_access_done;
  logic xfer_start, hold_next, xfer_done, irq_req;
  logic [3:0] xfer_channel, irq_vector;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  logic [1:0] slow;
  int held;

  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;

  // phase counter on the falling edge, so tasks read it settled after a rising edge
  always @(negedge clk_sys) cyc <= sys_rst ? 0 : cyc + 1;

  etei_pin_model pins (.clk_sys(clk_sys), .want(want), .fast_irq_pin(fast_irq_pin),
    .regular_irq_pin(regular_irq_pin), .aux_timer_a_input_pin(aux_a_pin), .aux_timer_b_input_pin(aux_b_pin));

  etei_top #(.TIMER_W(16)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_irq_pin(fast_irq_pin), .regular_irq_pin(regular_irq_pin), .aux_timer_a_input_pin(aux_a_pin),
    .aux_timer_b_input_pin(aux_b_pin), .core_timer(core_timer), .cpu_last_state(cpu[9]),
    .cpu_hold_early(cpu[8]), .cpu_hold_late(cpu[7]), .cpu_code_or_call(cpu[6]), .cpu_reads_status(cpu[5]),
    .cpu_prev_sets_flags(cpu[4]), .cpu_reads_xfer_ctrl(cpu[3]), .cpu_ext_fetch(cpu[2]),
    .cpu_ext_read(cpu[1]), .cpu_ext_write(cpu[0]), .bus_access_done(bus_access_done),
    .xfer_src_slow(slow[1]), .xfer_dst_ext(slow[0]), .xfer_start(xfer_start), .xfer_channel(xfer_channel),
    .hold_next(hold_next), .xfer_done(xfer_done), .irq_req(irq_req), .irq_vector(irq_vector));

  task automatic stop_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one transfer, then an idle edge so psel is never driven twice in one step
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      stop_test();
    end
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask : rd

  // a rise sets the flag only for codes with bit 0; after the fall any non-off code has set it
  task automatic sweep(input logic [15:0] cfg, input int src, input int sh, input int lag,
                       input logic [31:0] base, input int first);
    logic [31:0] r;
    for (int s = first; s < 4; s++) begin
      wr(cfg, base | (32'(s) << sh));
      wr(etei_pkg::ADDR_FLAGS, 32'h0000_03ff);
      want[src] <= 1'b1;
      repeat (lag) @(posedge clk_sys);
      rd(etei_pkg::ADDR_FLAGS, r);
      check(32'(r[src]), 32'(s & 1));
      want[src] <= 1'b0;
      repeat (lag) @(posedge clk_sys);
      rd(etei_pkg::ADDR_FLAGS, r);
      check(32'(r[src]), 32'(s != 0));
    end
  endtask : sweep

  task automatic t_reset;
    logic [31:0] r;
    logic e;
    rd(etei_pkg::ADDR_REG_CFG, r);
    check(r, 32'h0000_0000);
    wr(etei_pkg::ADDR_REG_CFG, 32'hffff_ffff);
    rd(etei_pkg::ADDR_REG_CFG, r);
    check(r, 32'h0000_03ff);
    wr(etei_pkg::ADDR_REG_CFG, 32'h0000_0000);
    apb(1'b0, 16'hdf3c, 32'h0000_0000, r, e);
    check({r[30:0], e}, 32'h0000_0001);
  endtask : t_reset

  task automatic t_pins;
    logic [31:0] r;
    sweep(etei_pkg::ADDR_FAST_CFG, 0, 0, 8, 32'h0000_0000, 0);
    wr(etei_pkg::ADDR_ENABLE, 32'h0000_0001);
    repeat (2) @(negedge clk_sys);
    check({27'h0, irq_req, irq_vector}, 32'h0000_0010);
    wr(etei_pkg::ADDR_ENABLE, 32'h0000_0000);
    sweep(etei_pkg::ADDR_REG_CFG, 4, 2, 24, 32'h0000_0000, 0);
    // a held high level keeps setting the flag after software clears it
    wr(etei_pkg::ADDR_REG_CFG, 32'h0000_0003);
    want[3] <= 1'b1;
    repeat (24) @(posedge clk_sys);
    wr(etei_pkg::ADDR_FLAGS, 32'h0000_0008);
    repeat (24) @(posedge clk_sys);
    rd(etei_pkg::ADDR_FLAGS, r);
    check(32'(r[3]), 32'h0000_0001);
    want[3] <= 1'b0;
    wr(etei_pkg::ADDR_REG_CFG, 32'h0000_0000);
  endtask : t_pins

  task automatic t_capture;
    logic [31:0] r;
    sweep(etei_pkg::ADDR_AUXA_CTL, 8, 3, 8, 32'h0000_0005, 1);
    rd(etei_pkg::ADDR_AUXA_VAL, r);
    check(r, 32'h0000_5a3c);
    core_timer <= 16'h3c5a;
    sweep(etei_pkg::ADDR_AUXB_CTL, 9, 3, 8, 32'h0000_0005, 1);
    rd(etei_pkg::ADDR_AUXB_VAL, r);
    check(r, 32'h0000_3c5a);
    // rising edge selected but not in capture mode: pin is no interrupt input
    sweep(etei_pkg::ADDR_AUXA_CTL, 8, 3, 8, 32'h0000_0000, 4);
    wr(etei_pkg::ADDR_AUXA_CTL, 32'h0000_0008);
    wr(etei_pkg::ADDR_FLAGS, 32'h0000_03ff);
    want[8] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(etei_pkg::ADDR_FLAGS, r);
    check(32'(r[8]), 32'h0000_0000);
    want[8] <= 1'b0;
  endtask : t_capture

  // pin edge at a fixed divider phase, so runs differ only by the pipeline conditions
  task automatic measure(input logic [9:0] c, input int pa, input int pn, output logic [31:0] t);
    int n;
    int h;
    logic [31:0] r;
    cpu <= c;
    while (cyc[2:0] != 3'h0) @(posedge clk_sys);
    want[0] <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      bus_access_done <= (n >= pa && n < pa + pn);
      @(negedge clk_sys);
    end while (xfer_start !== 1'b1 && n < 300);
    t = 32'(n);
    h = 0;
    while (xfer_done !== 1'b1 && n < 600) begin
      h += int'(hold_next === 1'b1);
      @(posedge clk_sys);
      n++;
      // slow source and external destination: two one-cycle bus words right after acknowledge
      bus_access_done <= (slow == 2'b11 && n <= int'(t) + 2);
      @(negedge clk_sys);
    end
    held = h;
    if (n >= 300 && t >= 300 || n >= 600) begin
      bad_count++;
      stop_test();
    end
    check({28'h0, xfer_channel}, 32'h0000_0000);
    check(32'(h >= 5), 32'h0000_0001);
    @(posedge clk_sys);
    rd(etei_pkg::ADDR_FLAGS, r);
    check(32'(r[0]), 32'h0000_0000);
    want[0] <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask : measure

  task automatic t_timing;
    logic [31:0] ta, tb, tc, td, te, tf, tg, th, ti, tj;
    int ha;
    wr(etei_pkg::ADDR_FAST_CFG, 32'h0000_0001);
    wr(etei_pkg::ADDR_FLAGS, 32'h0000_03ff);
    wr(etei_pkg::ADDR_XSEL, 32'h0000_0001);
    wr(etei_pkg::ADDR_ENABLE, 32'h0000_0001);
    measure(10'h270, 0, 0, ta);
    ha = held;
    measure(10'h070, 0, 0, tb);
    measure(10'h370, 0, 0, tc);
    measure(10'h3f0, 0, 0, td);
    measure(10'h1f0, 0, 0, te);
    measure(10'h1f8, 0, 0, tf);
    // last bus word ends on a state boundary, so the two states after the fetch are whole states
    measure(10'h007, 21, 7, tg);
    measure(10'h004, 27, 1, th);
    measure(10'h004, 37, 1, ti);
    check(tb - ta, 32'h0000_0002);
    check(tc - ta, 32'h0000_0002);
    check(te, td);
    check(tf - te, 32'h0000_0002);
    check(th - tg, 32'h0000_0004);
    check(ti - th, 32'h0000_000a);
    slow <= 2'b11;
    measure(10'h270, 0, 0, tj);
    slow <= 2'b00;
    check(tj, ta);
    check(32'(held - ha), 32'h0000_0002);
  endtask : t_timing

  // all inputs valid at time zero; reset held for four edges
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, bus_access_done} = 4'h0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    want = 10'h000;
    cpu = 10'h000;
    slow = 2'b00;
    core_timer = 16'h5a3c;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_pins();
    t_capture();
    t_timing();
    stop_test();
  end
endmodule : test_event_transfer_timing_and_ext_irq
